// >>> rtl/scc_cfg.svh
// Purpose: Offsets, field positions, reset values and codes of the serial channel control block.
// Assumes: Register indices are word indices; the APB byte address is four times the index.
// Notes: Definitions only.
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH

// ****************************************************************
// Register indices and byte addresses
// ****************************************************************
`define SCC_IDX_CLKSEL 16'hff43
`define SCC_IDX_MODE 16'hff60
`define SCC_IDX_SHIFT 16'hff61
`define SCC_IDX_OWNADDR 16'hff62
`define SCC_IDX_BITWR 16'hff63
`define SCC_IDX_OSC 16'hff64
`define SCC_IDX_STAT 16'hff65
`define SCC_IDX_MASK 16'hff66
`define SCC_BYTE_ADDR(idx) {idx, 2'b00}

// ****************************************************************
// Reset values
// ****************************************************************
`define SCC_RST_CLKSEL 8'h88
`define SCC_RST_MODE 8'h00
`define SCC_RST_BYTE 8'h00

// ****************************************************************
// Field positions and codes
// ****************************************************************
`define SCC_MODE_EN 7
`define SCC_MODE_MATCH 6
`define SCC_MODE_WAKE 5
`define SCC_MODE_SEL2 4
`define SCC_MODE_SEL1 3
`define SCC_MODE_SEL0 2
`define SCC_MODE_SRC1 1
`define SCC_MODE_SRC0 0
`define SCC_BITWR_VAL 3
`define SCC_STAT_DONE 0
`define SCC_STAT_MATCH 1
`define SCC_DIV_CODE_MIN 4'h6
`define SCC_DIV_CODE_MAX 4'hd
`define SCC_LAST_BIT 4'h7
`define SCC_RISE_COUNT 4'h8
`define SCC_PIN_SCK 0
`define SCC_PIN_SB0 1
`define SCC_PIN_SB1 2

`endif

// >>> rtl/scc_pkg.sv
// Purpose: Types shared by the serial channel control block.
// Assumes: Constants live in scc_cfg.svh.
// Notes: Pin bundles carry output and enable per pin.
package scc_pkg;

  typedef enum logic [1:0] {
    SCC_IDLE = 2'b01,
    SCC_RUN = 2'b10
  } scc_state_type;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic sb0_o;
    logic sb0_oe;
    logic sb1_o;
    logic sb1_oe;
  } scc_pins_type;

  typedef struct packed {
    logic three_wire;
    logic bus;
    logic two_wire;
    logic lsb_first;
    logic line_a;
  } scc_mode_type;

endpackage

// >>> rtl/scc_clk_div.sv
// Purpose: Divides the main clock into shift-clock half-period ticks for two channels.
// Assumes: pclk is the oscillator clock; the main clock is pclk or pclk/2.
// Notes: A prohibited code yields no tick, so a transfer simply stalls.
`timescale 1ns/10ps
`default_nettype none
`include "scc_cfg.svh"

module scc_clk_div (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic clk_en, // Freezes all state while low.
  input wire logic full_speed, // Main clock equals the oscillator clock.
  input wire logic [7:0] clock_sel, // Divider codes, low nibble channel 0.
  output logic [1:0] tick // Half-period tick per channel.
);

  logic half_q;
  logic [7:0] cnt_q;
  logic fxx_en;

  // The main clock runs at the oscillator rate or at half of it.
  assign fxx_en = full_speed | half_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_q <= 1'b0;
      cnt_q <= 8'h00;
    end else if (clk_en) begin
      half_q <= ~half_q;
      if (fxx_en) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  // A tick toggles the shift clock, so a code for divide by 2^n ticks every 2^(n-1) cycles.
  for (genvar i = 0; i < 2; i++) begin : g_chan
    logic [3:0] code;
    logic [2:0] sh;
    logic [7:0] mask;
    logic legal;
    assign code = clock_sel[4*i +: 4];
    assign legal = (code >= `SCC_DIV_CODE_MIN) && (code <= `SCC_DIV_CODE_MAX);
    assign sh = 3'(code - `SCC_DIV_CODE_MIN);
    assign mask = (8'h01 << sh) - 8'h01;
    assign tick[i] = clk_en & fxx_en & legal & ((cnt_q & mask) == mask);
  end

endmodule
`default_nettype wire

// >>> rtl/scc_ctrl.sv
// Purpose: Clock-select and mode registers of serial channel 0 with the shifter they steer.
// Assumes: APB slave; one clock; pins are synchronised here.
// Notes: Status bit clears are write-one; a set in the same cycle wins.
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "scc_cfg.svh"

module scc_ctrl (
  input wire logic pclk, // Clock, 125 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic clk_en, // Freezes all state while low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [17:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB byte strobes.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire logic timer2_output, // Timer 2 tick, same clock.
  input wire logic sck_in, // Serial clock pin level.
  input wire logic sb0_in, // Data pin a level.
  input wire logic sb1_in, // Data pin b level.
  output scc_pkg::scc_pins_type pins, // Pin outputs and enables.
  output logic channel1_tick, // Half-period tick for channel 1.
  output logic irq // Level interrupt.
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [7:0] clk_sel_q;
  logic [7:0] mode_q;
  logic [7:0] shift_q;
  logic [7:0] shift_nx;
  logic [7:0] own_addr_q;
  logic full_speed_q;
  logic [1:0] stat_q;
  logic [1:0] stat_set;
  logic [1:0] mask_q;
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic sck_s3_q;
  logic [3:0] cnt_q;
  logic sck_q;
  logic dout_q;
  logic match_q;
  scc_pkg::scc_state_type state_q;
  scc_pkg::scc_mode_type md;
  scc_pkg::scc_pins_type pins_d;
  logic [1:0] div_tick;
  logic [31:0] rd_d;
  logic hit;
  logic acc_first;
  logic commit;
  logic wr_ok;
  logic addr_match;
  logic int_tick;
  logic rise;
  logic fall;
  logic din;
  logic done_evt;
  logic xfer_evt;
  logic samp;
  logic last;

  // ****************************************************************
  // Decode
  // ****************************************************************
  always_comb begin
    md.three_wire = ~mode_q[`SCC_MODE_SEL2];
    md.bus = mode_q[`SCC_MODE_SEL2] & ~mode_q[`SCC_MODE_SEL1];
    md.two_wire = mode_q[`SCC_MODE_SEL2] & mode_q[`SCC_MODE_SEL1];
    md.lsb_first = ~mode_q[`SCC_MODE_SEL2] & mode_q[`SCC_MODE_SEL0];
    md.line_a = mode_q[`SCC_MODE_SEL2] & mode_q[`SCC_MODE_SEL0];
  end

  assign addr_match = mode_q[`SCC_MODE_EN] & (own_addr_q == shift_q);

  // ****************************************************************
  // Clock divider
  // ****************************************************************
  scc_clk_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .full_speed(full_speed_q),
    .clock_sel(clk_sel_q),
    .tick(div_tick)
  );

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= 3'h7;
      pin_s2_q <= 3'h7;
      sck_s3_q <= 1'b1;
    end else if (clk_en) begin
      pin_s1_q <= {sb1_in, sb0_in, sck_in};
      pin_s2_q <= pin_s1_q;
      sck_s3_q <= pin_s2_q[`SCC_PIN_SCK];
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // The answer takes one wait state so read data comes from a flip-flop.
  assign acc_first = psel & penable & ~pready;
  assign commit = psel & penable & pready;
  assign wr_ok = commit & pwrite & hit & pstrb[0] & clk_en;

  always_comb begin
    hit = 1'b1;
    rd_d = 32'h0000_0000;
    case (paddr)
      `SCC_BYTE_ADDR(`SCC_IDX_CLKSEL): rd_d[7:0] = clk_sel_q;
      `SCC_BYTE_ADDR(`SCC_IDX_MODE): begin
        rd_d[7:0] = mode_q;
        rd_d[`SCC_MODE_MATCH] = addr_match;
      end
      `SCC_BYTE_ADDR(`SCC_IDX_SHIFT): rd_d[7:0] = shift_q;
      `SCC_BYTE_ADDR(`SCC_IDX_OWNADDR): rd_d[7:0] = own_addr_q;
      `SCC_BYTE_ADDR(`SCC_IDX_BITWR): rd_d = 32'h0000_0000;
      `SCC_BYTE_ADDR(`SCC_IDX_OSC): rd_d[0] = full_speed_q;
      `SCC_BYTE_ADDR(`SCC_IDX_STAT): rd_d[1:0] = stat_q;
      `SCC_BYTE_ADDR(`SCC_IDX_MASK): rd_d[1:0] = mask_q;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (clk_en) begin
      pready <= acc_first;
      pslverr <= acc_first & ~hit;
      if (acc_first && !pwrite) begin
        prdata <= rd_d;
      end
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sel_q <= `SCC_RST_CLKSEL;
      mode_q <= `SCC_RST_MODE;
      own_addr_q <= `SCC_RST_BYTE;
      full_speed_q <= 1'b0;
      mask_q <= 2'h0;
    end else if (wr_ok) begin
      case (paddr)
        // The clock select only takes a whole byte; software stops transfers first.
        `SCC_BYTE_ADDR(`SCC_IDX_CLKSEL): clk_sel_q <= pwdata[7:0];
        `SCC_BYTE_ADDR(`SCC_IDX_MODE): begin
          mode_q <= pwdata[7:0] & ~(8'h01 << `SCC_MODE_MATCH);
        end
        `SCC_BYTE_ADDR(`SCC_IDX_BITWR): begin
          if (pwdata[2:0] != 3'(`SCC_MODE_MATCH)) begin
            mode_q[pwdata[2:0]] <= pwdata[`SCC_BITWR_VAL];
          end
        end
        `SCC_BYTE_ADDR(`SCC_IDX_OWNADDR): own_addr_q <= pwdata[7:0];
        `SCC_BYTE_ADDR(`SCC_IDX_OSC): full_speed_q <= pwdata[0];
        `SCC_BYTE_ADDR(`SCC_IDX_MASK): mask_q <= pwdata[1:0];
        default: mask_q <= mask_q;
      endcase
    end
  end

  // ****************************************************************
  // Shifter
  // ****************************************************************
  // Internal sources toggle the local clock; an external clock is edge-detected.
  assign int_tick = mode_q[`SCC_MODE_SRC0] ? div_tick[0] : timer2_output;
  assign rise = mode_q[`SCC_MODE_SRC1] ? (int_tick & ~sck_q)
    : (pin_s2_q[`SCC_PIN_SCK] & ~sck_s3_q);
  assign fall = mode_q[`SCC_MODE_SRC1] ? (int_tick & sck_q & (cnt_q != `SCC_RISE_COUNT))
    : (~pin_s2_q[`SCC_PIN_SCK] & sck_s3_q);
  // With our own clock the far end's bit comes back through the pin register and the
  // synchroniser four cycles late, so it is taken at the tick after the rise instead.
  assign samp = mode_q[`SCC_MODE_SRC1] ? (int_tick & sck_q & (cnt_q != 4'h0)) : rise;
  assign last = mode_q[`SCC_MODE_SRC1] ? (cnt_q == `SCC_RISE_COUNT)
    : (cnt_q == `SCC_LAST_BIT);
  assign din = md.three_wire ? pin_s2_q[`SCC_PIN_SB0]
    : (md.line_a ? pin_s2_q[`SCC_PIN_SB0] : pin_s2_q[`SCC_PIN_SB1]);
  assign shift_nx = md.lsb_first ? {din, shift_q[7:1]} : {shift_q[6:0], din};
  assign done_evt = (state_q == scc_pkg::SCC_RUN) & samp & last & mode_q[`SCC_MODE_EN];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= scc_pkg::SCC_IDLE;
      shift_q <= `SCC_RST_BYTE;
      cnt_q <= 4'h0;
      sck_q <= 1'b1;
      dout_q <= 1'b1;
    end else if (clk_en) begin
      if (wr_ok && paddr == `SCC_BYTE_ADDR(`SCC_IDX_SHIFT)) begin
        shift_q <= pwdata[7:0];
        cnt_q <= 4'h0;
        sck_q <= 1'b1;
        dout_q <= md.lsb_first ? pwdata[0] : pwdata[7];
        state_q <= mode_q[`SCC_MODE_EN] ? scc_pkg::SCC_RUN : scc_pkg::SCC_IDLE;
      end else if (!mode_q[`SCC_MODE_EN]) begin
        state_q <= scc_pkg::SCC_IDLE;
        sck_q <= 1'b1;
      end else begin
        case (state_q)
          scc_pkg::SCC_IDLE: sck_q <= 1'b1;
          scc_pkg::SCC_RUN: begin
            if (mode_q[`SCC_MODE_SRC1] && (rise || fall)) begin
              sck_q <= ~sck_q;
            end
            if (fall) begin
              dout_q <= samp ? (md.lsb_first ? shift_nx[0] : shift_nx[7])
                : (md.lsb_first ? shift_q[0] : shift_q[7]);
            end
            if (samp) begin
              shift_q <= shift_nx;
            end
            if (rise) begin
              cnt_q <= cnt_q + 4'h1;
            end
            if (done_evt) begin
              state_q <= scc_pkg::SCC_IDLE;
            end
          end
          default: state_q <= scc_pkg::SCC_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // Pins
  // ****************************************************************
  always_comb begin
    pins_d = '0;
    if (mode_q[`SCC_MODE_EN]) begin
      if (md.three_wire) begin
        // Data pin a stays input only; it carries the serial input that the shifter samples.
        pins_d.sb1_o = dout_q;
        pins_d.sb1_oe = 1'b1;
      end else if (md.line_a) begin
        pins_d.sb0_oe = ~dout_q;
      end else begin
        pins_d.sb1_oe = ~dout_q;
      end
      if (mode_q[`SCC_MODE_SRC1]) begin
        pins_d.sck_o = md.two_wire ? 1'b0 : sck_q;
        pins_d.sck_oe = md.two_wire ? ~sck_q : 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins <= '0;
      channel1_tick <= 1'b0;
    end else if (clk_en) begin
      pins <= pins_d;
      channel1_tick <= div_tick[1];
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  // With wakeup in bus mode only a byte that matches the own address interrupts.
  assign xfer_evt = done_evt & (~(mode_q[`SCC_MODE_WAKE] & md.bus)
    | (own_addr_q == shift_nx));
  assign stat_set = {addr_match & ~match_q, xfer_evt};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= 2'h0;
      match_q <= 1'b0;
      irq <= 1'b0;
    end else if (clk_en) begin
      match_q <= addr_match;
      if (wr_ok && paddr == `SCC_BYTE_ADDR(`SCC_IDX_STAT)) begin
        stat_q <= (stat_q & ~pwdata[1:0]) | stat_set;
        irq <= |(((stat_q & ~pwdata[1:0]) | stat_set) & mask_q);
      end else begin
        stat_q <= stat_q | stat_set;
        irq <= |((stat_q | stat_set) & mask_q);
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_clksel_byte_only: assert property (
    commit && pwrite && !pstrb[0] |=> $stable(clk_sel_q))
    else $error("clock select changed on a partial write");
  a_div_legal_code: assert property (
    div_tick[0] |-> clk_sel_q[3:0] >= 4'h6 && clk_sel_q[3:0] <= 4'hd)
    else $error("channel 0 tick on a prohibited code");
  a_ch1_legal_code: assert property (
    clk_en && channel1_tick |-> $past(clk_sel_q[7:4]) >= 4'h6 && $past(clk_sel_q[7:4]) <= 4'hd)
    else $error("channel 1 tick on a prohibited code");
  a_mode_byte_write: assert property (
    wr_ok && paddr == 18'h3fd80 |=> mode_q == ($past(pwdata[7:0]) & 8'hbf))
    else $error("mode byte write not stored");
  a_bit_write_lands: assert property (
    wr_ok && paddr == 18'h3fd8c && pwdata[2:0] != 3'h6
    |=> mode_q[$past(pwdata[2:0])] == $past(pwdata[3]))
    else $error("mode bit write not stored");
  a_match_not_stored: assert property (mode_q[6] == 1'b0)
    else $error("match flag stored by a write");
  a_ext_clock_quiet: assert property (
    clk_en && pins.sck_oe |-> $past(mode_q[1]))
    else $error("clock pin driven with an external source");
  a_lsb_order: assert property (
    clk_en && state_q == scc_pkg::SCC_RUN && samp && md.lsb_first && mode_q[7]
    && !wr_ok |=> shift_q[7] == $past(din))
    else $error("lsb-first sample not placed at the top");
  a_si_pin_free: assert property (
    clk_en && $past(md.three_wire) |-> !pins.sb0_oe)
    else $error("serial input pin driven in 3-wire mode");
  a_free_line_b: assert property (
    clk_en && $past(md.line_a) |-> !pins.sb1_oe)
    else $error("unchosen data pin driven");
  a_open_drain_low: assert property (
    clk_en && $past(mode_q[4]) |-> !pins.sb0_o && !pins.sb1_o)
    else $error("bus line driven high");
  a_start_xfer: assert property (
    wr_ok && paddr == 18'h3fd84 && mode_q[7] |=> state_q == scc_pkg::SCC_RUN ##0 cnt_q == 4'h0)
    else $error("shift write did not start a transfer");
  a_match_off_zero: assert property (!mode_q[7] |-> !addr_match)
    else $error("match flag set while disabled");
  a_wakeup_gate: assert property (
    done_evt && mode_q[5] && md.bus && own_addr_q != shift_nx && !stat_q[0] |=> !stat_q[0])
    else $error("wakeup interrupt without address match");

endmodule
`default_nettype wire

// >>> verif/scc_far_end.sv
// Purpose: Far-end serial device that resolves the pin wires and trades one byte.
// Assumes: Data and clock lines are pulled up; an undriven wire reads high.
// Notes: Behavioural; the bench arms it before each transfer.
`timescale 1ns/10ps
`default_nettype none

module scc_far_end (
  input wire scc_pkg::scc_pins_type pins, // Block pin drives.
  input wire logic arm, // Rising edge clears counts.
  input wire logic rd_a, // Sample line a, else line b.
  input wire logic wr_a, // Drive line a, else line b.
  input wire logic ext_go, // Rising edge sends eight clock pulses.
  input wire logic [7:0] tx, // Byte sent MSB first.
  output logic sck_in, // Clock wire.
  output logic sb0_in, // Line a wire.
  output logic sb1_in, // Line b wire.
  output logic [7:0] rx, // Byte seen, MSB first.
  output logic [3:0] cnt // Clock rises seen.
);
  // ****
  // Wires and shifter
  // ****
  logic ext_clk = 1'b1;
  logic drv = 1'b1;
  logic [2:0] idx = 3'h7;

  // Wired-AND with pull-up, so the far end never fights a low driver.
  assign sck_in = pins.sck_oe ? pins.sck_o : ext_clk;
  assign sb0_in = (pins.sb0_oe ? pins.sb0_o : 1'b1) & (wr_a ? drv : 1'b1);
  assign sb1_in = (pins.sb1_oe ? pins.sb1_o : 1'b1) & (wr_a ? 1'b1 : drv);

  always @(posedge arm) begin
    cnt = 4'h0;
    idx = 3'h7;
    rx = 8'h00;
    drv = 1'b1;
  end

  // Data changes on the fall so it is stable at the following rise.
  always @(negedge sck_in) begin
    if (cnt < 4'h8) begin
      drv = tx[idx];
      idx = idx - 3'h1;
    end
  end

  always @(posedge sck_in) begin
    if (cnt < 4'h8) begin
      rx = {rx[6:0], rd_a ? sb0_in : sb1_in};
      // The last bit stays on the wire until the next arm, so a late sampler still sees it.
      cnt = cnt + 4'h1;
    end
  end

  always @(posedge ext_go) begin
    // Edges fall between bench clock edges, so the synchronisers never race the wire.
    #2;
    repeat (8) begin
      #80 ext_clk = 1'b0;
      #80 ext_clk = 1'b1;
    end
  end
endmodule

`default_nettype wire

// >>> verif/tb_top.sv
// Purpose: Self-checking bench for the serial channel control block.
// Assumes: APB slave answers with pready; the far end is scc_far_end.
// Notes: Expected values come from the register model here, never from the block.
`timescale 1ns/10ps
`default_nettype none
`include "scc_cfg.svh"

module tb_top;
  // ****
  // Stimulus, model and checks
  // ****
  localparam logic [17:0] A_CS = `SCC_BYTE_ADDR(`SCC_IDX_CLKSEL),
    A_MODE = `SCC_BYTE_ADDR(`SCC_IDX_MODE),
    A_SH = `SCC_BYTE_ADDR(`SCC_IDX_SHIFT),
    A_OWN = `SCC_BYTE_ADDR(`SCC_IDX_OWNADDR),
    A_BW = `SCC_BYTE_ADDR(`SCC_IDX_BITWR),
    A_OSC = `SCC_BYTE_ADDR(`SCC_IDX_OSC),
    A_ST = `SCC_BYTE_ADDR(`SCC_IDX_STAT),
    A_MASK = `SCC_BYTE_ADDR(`SCC_IDX_MASK);
  localparam logic [17:0] AMAP [8] = '{A_CS, A_MODE, A_SH, A_OWN, A_BW, A_OSC, A_ST, A_MASK};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, timer2_output = 0;
  logic arm = 0, rd_a = 0, wr_a = 0, ext_go = 0, clr = 0;
  logic pready, pslverr, channel1_tick, irq, sck_in, sb0_in, sb1_in, sck_d;
  logic [17:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, seed = 32'h8c51;
  logic [3:0] pstrb = 0, cnt;
  logic [7:0] tx = 0, rx;
  logic [2:0] seen = 0;
  scc_pkg::scc_pins_type pins;
  int fail_count = 0, num_checks = 0, cyc = 0, rise_t = 0, per = 0, tick_t = 0, tgap = 0;
  int mdl [int];

  scc_ctrl DUT (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer2_output(timer2_output), .sck_in(sck_in),
    .sb0_in(sb0_in), .sb1_in(sb1_in), .pins(pins), .channel1_tick(channel1_tick), .irq(irq)
  );

  scc_far_end FAR (
    .pins(pins), .arm(arm), .rd_a(rd_a), .wr_a(wr_a), .ext_go(ext_go), .tx(tx),
    .sck_in(sck_in), .sb0_in(sb0_in), .sb1_in(sb1_in), .rx(rx), .cnt(cnt)
  );

  always #4 pclk = ~pclk;

  // Wire clock period, channel 1 tick spacing and pin drive history.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    sck_d <= sck_in;
    timer2_output <= (cyc % 7 == 0);
    if (sck_in && !sck_d) begin
      per <= cyc - rise_t;
      rise_t <= cyc;
    end
    if (channel1_tick) begin
      tgap <= cyc - tick_t;
      tick_t <= cyc;
    end
    seen <= clr ? 3'h0 : seen | {pins.sck_oe, pins.sb1_oe, pins.sb0_oe};
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] rv(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rv[i] = v[7 - i];
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic mreset();
    foreach (AMAP[k]) mdl[AMAP[k]] = 0;
    mdl[A_CS] = 8'h88;
  endtask

  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 20) fail_count++;
  endtask

  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1, a, d, 4'hf, r, e);
    chk(e, !mdl.exists(a));
    if (a == A_ST) mdl[a] = mdl[a] & ~d;
    else if (a == A_BW) begin
      if (d[2:0] != 3'h6) mdl[A_MODE][d[2:0]] = d[3];
    end else if (a == A_MODE) mdl[a] = d & 32'hbf;
    else if (mdl.exists(a)) mdl[a] = d & 32'hff;
  endtask

  task automatic rd(input logic [17:0] a);
    logic [31:0] r, x;
    logic e;
    apb(0, a, 0, 4'h0, r, e);
    x = mdl.exists(a) ? mdl[a] : 0;
    if (a == A_MODE) x[6] = x[7] && (mdl[A_OWN] == mdl[A_SH]);
    chk(r, x);
    chk(e, !mdl.exists(a));
  endtask

  // One byte each way; pe is the expected wire period, zero to skip it.
  task automatic xfer(input logic [7:0] m, input int pe, input logic st);
    logic [31:0] r;
    logic [7:0] d, t;
    int n;
    n = 0;
    r = rnd();
    d = {1'b0, r[6:0]};
    t = {1'b0, r[14:8]};
    wr(A_MODE, {1'b0, m[6:0]});
    wr(A_MODE, m);
    rd_a <= m[4] & m[2];
    wr_a <= !(m[4] & !m[2]);
    tx <= t;
    arm <= 1;
    clr <= 1;
    wr(A_SH, d);
    arm <= 0;
    clr <= 0;
    ext_go <= !m[1];
    while (irq !== 1'b1 && n < 9000) begin
      @(posedge pclk);
      n++;
    end
    ext_go <= 0;
    chk(irq, st & mdl[A_MASK][0]);
    chk(cnt, 8);
    chk(rx, m[4] ? d & t : (m[2] ? rv(d) : d));
    chk(seen, {m[1], !(m[4] & m[2]), m[4] & m[2]});
    if (pe > 0) chk(per, pe);
    mdl[A_SH] = m[4] ? d & t : (m[2] ? rv(t) : t);
    mdl[A_ST] = st;
    rd(A_SH);
    rd(A_ST);
    wr(A_ST, 3);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
  endtask

  initial begin
    logic [31:0] r;
    logic e;
    mreset();
    repeat (6) @(posedge pclk);
    presetn <= 1;
    rd(A_CS);
    rd(A_MODE);
    rd(A_OSC);
    rd(A_MASK);
    rd(18'h0);
    wr(18'h4, 5);
    apb(1, A_CS, 32'h66, 4'he, r, e);
    rd(A_CS);
    wr(A_MODE, 8'h40);
    rd(A_MODE);
    wr(A_BW, 8'hd);
    rd(A_MODE);
    wr(A_BW, 8'he);
    rd(A_MODE);
    wr(A_BW, 8'h5);
    rd(A_BW);
    rd(A_MODE);
    wr(A_OWN, 8'hff);
    wr(A_MASK, 8'h01);
    for (int i = 0; i < 8; i++) begin
      wr(A_CS, {4'(13 - i), 4'(6 + i)});
      xfer(8'h83 | 8'(i << 2), 4 << i, 1);
      repeat ((600 >> i) + 4) @(posedge pclk);
      chk(tgap, 256 >> i);
    end
    wr(A_OSC, 1);
    wr(A_CS, 8'h87);
    xfer(8'h87, 4, 1);
    wr(A_OSC, 0);
    xfer(8'h82, 0, 1);
    xfer(8'h80, 0, 1);
    xfer(8'hb3, 0, 0);
    wr(A_MASK, 0);
    xfer(8'h83, 0, 1);
    wr(A_OWN, mdl[A_SH]);
    mdl[A_ST] = 2;
    rd(A_MODE);
    rd(A_ST);
    wr(A_MODE, 0);
    rd(A_MODE);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    mreset();
    rd(A_CS);
    rd(A_MODE);
    test_done();
  end

  initial begin
    repeat (60000) @(posedge pclk);
    fail_count++;
    test_done();
  end
endmodule

`default_nettype wire
